// File: rtl/nbx_exec.sv
// Execute unit of the nibble core: arithmetic, logic, branches and skips
// What this block does
// - Register add: sum to accumulator, optional RAM write
// - Immediate add: sum to accumulator, optional register write
// - Add-with-carry adds carry flag to sum
// - Keep-carry add changes only zero flag
// - Subtract memory minus accumulator or immediate
// - Write-back subtract also stores source location
// - Subtract-with-borrow also subtracts carry flag
// - Increment/decrement RAM nibble into both; bit7 decrements
// - AND result to accumulator, zero flag only
// - OR result to accumulator, zero flag only
// - XOR result to accumulator, zero flag only
// - Logic write-back forms also store source location
// - Accumulator-bit branch loads low eleven PC bits
// - Branch on accumulator zero or non-zero
// - Branch on carry set or clear
// - Decrement then skip on zero or non-zero
// - Skip when selected RAM bit set, flags kept
// - Paged address is page times 10H plus offset
`timescale 1ns/1ps
`include "nbx_consts.svh"
module nbx_exec
	import nbx_pkg::*;
#(
	parameter int PC_W   = 13,  // Program counter width
	parameter int RAM_AW = 7    // Data RAM address width
) (
	input  wire logic              clk,        // Core clock, 100 MHz
	input  wire logic              reset,      // Synchronous, active high
	input  wire logic              psel,       // APB select
	input  wire logic              penable,    // APB access phase
	input  wire logic              pwrite,     // APB direction
	input  wire logic [7:0]        paddr,      // APB byte address
	input  wire logic [31:0]       pwdata,     // APB write data
	output logic      [31:0]       prdata,     // APB read data
	output logic                   pready,     // APB ready
	output logic                   pslverr,    // APB error
	output logic      [PC_W-1:0]   prog_addr,  // Program memory address
	input  wire logic [15:0]       prog_data,  // Program word, one cycle after address
	output logic      [RAM_AW-1:0] ram_addr,   // Data RAM address
	input  wire logic [3:0]        ram_rdata,  // RAM nibble, one cycle after address
	output logic      [3:0]        ram_wdata,  // RAM write nibble
	output logic                   ram_we      // RAM write strobe
);
	// Widths below these cannot hold a jump target or a paged address
	if (PC_W < 13 || PC_W > 16) begin : g_pc_chk
		$error("nbx_exec: PC_W must lie between 13 and 16");
	end
	if (RAM_AW < 7) begin : g_ram_chk
		$error("nbx_exec: RAM_AW must be at least 7");
	end

	// All core state in one record
	typedef struct packed {
		nbx_state_e        st;         // Sequencer state
		logic [PC_W-1:0]   pc;         // Program counter
		logic [15:0]       ir;         // Instruction being executed
		logic [3:0]        acc;        // Accumulator
		logic              zf;         // Zero flag
		logic              cf;         // Carry flag
		logic [RAM_AW-1:0] ram_addr;   // Operand address
		logic [3:0]        ram_wdata;  // Write-back nibble
		logic              ram_we;     // Write-back strobe
	} nbx_core_s;

	nbx_core_s   s_q;        // Registered state
	nbx_core_s   s_d;        // Next state
	nbx_alu_op_e alu_op;     // Operation for the current instruction
	logic [3:0]  alu_b;      // Second ALU operand
	logic [3:0]  alu_res;    // ALU result
	logic        alu_carry;  // ALU carry or borrow
	nbx_class_e  cls_exec;   // Class of the held instruction

	nbx_ctl_if #(.PC_W(PC_W)) ctl ();  // Link to the register slave

	// Paged operand address: page low bits times 10H plus offset
	function automatic logic [RAM_AW-1:0] page_addr(
		input logic [2:0] pg,
		input logic [3:0] off
	);
		page_addr = RAM_AW'(pg) * RAM_AW'(`NBX_DATA_PAGE_STRIDE) + RAM_AW'(off);
	endfunction

	// Sort an instruction word into the classes this unit executes
	function automatic nbx_class_e classify(input logic [15:0] w);
		classify = NBX_CL_OTHER;
		if (w[15:14] == 2'b00 && w[11]) begin
			classify = NBX_CL_ALU;
		end else if (w[15:8] == 8'h4a) begin
			classify = NBX_CL_INCDEC;
		end else if (w[15:8] == 8'h48) begin
			classify = NBX_CL_DSK;
		end else if (w[15:9] == 7'b1010_100) begin
			classify = NBX_CL_SKB;
		end else if (w[15:11] == 5'b0111_0) begin
			classify = NBX_CL_JMP;
		end else if (w[15:14] == 2'b10 && !w[11]) begin
			classify = NBX_CL_JBIT;
		end else if (w[15:11] == 5'b1110_0) begin
			classify = NBX_CL_JZ;
		end else if (w[15:11] == 5'b1100_0) begin
			classify = NBX_CL_JNZ;
		end else if (w[15:11] == 5'b1111_0) begin
			classify = NBX_CL_JC;
		end else if (w[15:11] == 5'b1101_0) begin
			classify = NBX_CL_JNC;
		end
	endfunction

	// ALU operation from the group bits; bit 9 picks the second of each pair
	function automatic nbx_alu_op_e alu_decode(input logic [15:0] w);
		alu_decode = NBX_OP_ADD;
		case (classify(w))
			NBX_CL_ALU: begin
				case (w[13:12])
					2'b00:   alu_decode = w[9] ? NBX_OP_SBC : NBX_OP_ADC;
					2'b01:   alu_decode = w[9] ? NBX_OP_SUB : NBX_OP_ADD;
					2'b10:   alu_decode = w[9] ? NBX_OP_AND : NBX_OP_ADD;
					default: alu_decode = w[9] ? NBX_OP_OR : NBX_OP_XOR;
				endcase
			end
			NBX_CL_INCDEC: alu_decode = w[7] ? NBX_OP_DEC : NBX_OP_INC;
			NBX_CL_DSK:    alu_decode = NBX_OP_DEC;
			default:       alu_decode = NBX_OP_ADD;
		endcase
	endfunction

	// Carry-affecting forms: the two upper groups keep the carry flag
	function automatic logic alu_sets_carry(input logic [15:0] w);
		alu_sets_carry = (w[13:12] == 2'b00) || (w[13:12] == 2'b01);
	endfunction

	// Register slave on APB
	nbx_apb_regs #(.PC_W(PC_W)) u_regs (
		.clk     (clk),
		.reset   (reset),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.ctl     (ctl)
	);

	// Operand steering: immediate forms use bits 7..4, register forms the accumulator
	assign cls_exec = classify(s_q.ir);
	assign alu_op   = alu_decode(s_q.ir);
	assign alu_b    = (cls_exec == NBX_CL_ALU && s_q.ir[10]) ? s_q.ir[7:4] : s_q.acc;

	// Shared ALU
	nbx_alu u_alu (
		.a     (ram_rdata),
		.b     (alu_b),
		.cin   (s_q.cf),
		.op    (alu_op),
		.res   (alu_res),
		.carry (alu_carry)
	);

	// Sequencer and execution: fetch, decode, operand wait, execute
	always_comb begin
		s_d        = s_q;
		s_d.ram_we = 1'b0;  // Write strobe lasts one cycle
		case (s_q.st)
			NBX_ST_HALT: begin
				// Software may move the program counter only while halted
				if (ctl.pc_load) begin
					s_d.pc = ctl.pc_wdata;
				end
				if (ctl.run) begin
					s_d.st = NBX_ST_FETCH;
				end
			end
			NBX_ST_FETCH: begin
				// Program address is out; memory answers next cycle
				s_d.st = ctl.run ? NBX_ST_DECODE : NBX_ST_HALT;
			end
			NBX_ST_DECODE: begin
				// Capture the word and aim the RAM at its operand
				s_d.ir = prog_data;
				s_d.st = NBX_ST_OPERAND;
				if (classify(prog_data) == NBX_CL_ALU && prog_data[10]) begin
					s_d.ram_addr = page_addr(ctl.data_page, prog_data[3:0]);
				end else begin
					s_d.ram_addr = RAM_AW'(prog_data[6:0]);
				end
			end
			NBX_ST_OPERAND: begin
				// RAM read latency: the nibble is valid in the next state
				s_d.st = NBX_ST_EXEC;
			end
			NBX_ST_EXEC: begin
				s_d.st = NBX_ST_FETCH;
				s_d.pc = s_q.pc + PC_W'(`NBX_SEQ_STEP);
				case (cls_exec)
					NBX_CL_ALU: begin
						s_d.acc = alu_res;
						s_d.zf  = (alu_res == 4'h0);
						if (alu_sets_carry(s_q.ir)) begin
							s_d.cf = alu_carry;
						end
						// Bit 8 marks the write-back form of every pair
						if (s_q.ir[8]) begin
							s_d.ram_we    = 1'b1;
							s_d.ram_wdata = alu_res;
						end
					end
					NBX_CL_INCDEC: begin
						s_d.acc       = alu_res;
						s_d.zf        = (alu_res == 4'h0);
						s_d.cf        = alu_carry;
						s_d.ram_we    = 1'b1;
						s_d.ram_wdata = alu_res;
					end
					NBX_CL_DSK: begin
						s_d.acc       = alu_res;
						s_d.zf        = (alu_res == 4'h0);
						s_d.cf        = alu_carry;
						s_d.ram_we    = 1'b1;
						s_d.ram_wdata = alu_res;
						// Bit 7 clear skips on zero, set skips on non-zero
						if ((alu_res == 4'h0) != s_q.ir[7]) begin
							s_d.pc = s_q.pc + PC_W'(`NBX_SKIP_STEP);
						end
					end
					NBX_CL_SKB: begin
						// Flags stay as they were
						if (ram_rdata[{s_q.ir[8], s_q.ir[7]}]) begin
							s_d.pc = s_q.pc + PC_W'(`NBX_SKIP_STEP);
						end
					end
					NBX_CL_JMP: begin
						s_d.pc = PC_W'(ctl.rom_page) * PC_W'(`NBX_ROM_PAGE_STRIDE)
							+ PC_W'(s_q.ir[10:0]);
					end
					NBX_CL_JBIT: begin
						if (s_q.acc[s_q.ir[13:12]]) begin
							s_d.pc[10:0] = s_q.ir[10:0];
						end
					end
					NBX_CL_JZ: begin
						if (s_q.acc == 4'h0) begin
							s_d.pc[10:0] = s_q.ir[10:0];
						end
					end
					NBX_CL_JNZ: begin
						if (s_q.acc != 4'h0) begin
							s_d.pc[10:0] = s_q.ir[10:0];
						end
					end
					NBX_CL_JC: begin
						if (s_q.cf) begin
							s_d.pc[10:0] = s_q.ir[10:0];
						end
					end
					NBX_CL_JNC: begin
						if (!s_q.cf) begin
							s_d.pc[10:0] = s_q.ir[10:0];
						end
					end
					default: begin
						// Other instruction groups belong elsewhere; step over them
						s_d.pc = s_q.pc + PC_W'(`NBX_SEQ_STEP);
					end
				endcase
			end
			default: s_d.st = NBX_ST_HALT;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q          <= '0;
			s_q.st       <= NBX_ST_HALT;
			s_q.pc       <= PC_W'(`NBX_RST_PC);
			s_q.acc      <= `NBX_RST_ACC;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs from flops
	assign prog_addr = s_q.pc;
	assign ram_addr  = s_q.ram_addr;
	assign ram_wdata = s_q.ram_wdata;
	assign ram_we    = s_q.ram_we;

	// Status back to the register slave
	assign ctl.acc  = s_q.acc;
	assign ctl.zf   = s_q.zf;
	assign ctl.cf   = s_q.cf;
	assign ctl.pc   = s_q.pc;
	assign ctl.busy = (s_q.st != NBX_ST_HALT);
endmodule

// File: rtl/nbx_consts.svh
// Register offsets, field positions, reset values and address arithmetic constants
`ifndef NBX_CONSTS_SVH
`define NBX_CONSTS_SVH

// APB register byte addresses
`define NBX_REG_CTRL        8'h00
`define NBX_REG_STATUS      8'h04
`define NBX_REG_PC          8'h08
`define NBX_REG_PAGE        8'h0c

// Field positions
`define NBX_CTRL_RUN        0
`define NBX_STAT_ACC_LSB    0
`define NBX_STAT_ZF         4
`define NBX_STAT_CF         5
`define NBX_STAT_BUSY       8
`define NBX_PAGE_ROM_LSB    0
`define NBX_PAGE_DATA_LSB   4

// Reset values
`define NBX_RST_ACC         4'h0
`define NBX_RST_PC          16'h0000
`define NBX_RST_ROM_PAGE    2'h0
`define NBX_RST_DATA_PAGE   3'h0

// Address arithmetic
`define NBX_DATA_PAGE_STRIDE 8'h10
`define NBX_ROM_PAGE_STRIDE  16'h0800
`define NBX_SKIP_STEP        16'h0002
`define NBX_SEQ_STEP         16'h0001

`endif

// File: rtl/nbx_pkg.sv
// Types shared by the execute unit, its ALU and its register slave
package nbx_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		NBX_ST_HALT    = 3'b000,
		NBX_ST_FETCH   = 3'b001,
		NBX_ST_DECODE  = 3'b010,
		NBX_ST_OPERAND = 3'b011,
		NBX_ST_EXEC    = 3'b100
	} nbx_state_e;

	// ALU operations
	typedef enum logic [3:0] {
		NBX_OP_ADD = 4'h0,
		NBX_OP_ADC = 4'h1,
		NBX_OP_SUB = 4'h2,
		NBX_OP_SBC = 4'h3,
		NBX_OP_AND = 4'h4,
		NBX_OP_OR  = 4'h5,
		NBX_OP_XOR = 4'h6,
		NBX_OP_INC = 4'h7,
		NBX_OP_DEC = 4'h8
	} nbx_alu_op_e;

	// Instruction classes handled here
	typedef enum logic [3:0] {
		NBX_CL_ALU    = 4'h0,
		NBX_CL_INCDEC = 4'h1,
		NBX_CL_DSK    = 4'h2,
		NBX_CL_SKB    = 4'h3,
		NBX_CL_JMP    = 4'h4,
		NBX_CL_JBIT   = 4'h5,
		NBX_CL_JZ     = 4'h6,
		NBX_CL_JNZ    = 4'h7,
		NBX_CL_JC     = 4'h8,
		NBX_CL_JNC    = 4'h9,
		NBX_CL_OTHER  = 4'ha
	} nbx_class_e;

endpackage

// File: rtl/nbx_ctl_if.sv
// Control and status carried between the register slave and the core
`timescale 1ns/1ps
interface nbx_ctl_if #(
	parameter int PC_W = 13
);
	logic            run;        // Core may execute
	logic            pc_load;    // One-cycle request to load the program counter
	logic [PC_W-1:0] pc_wdata;   // Value for that load
	logic [1:0]      rom_page;   // ROM page for the unconditional jump
	logic [2:0]      data_page;  // Page for working-register operands
	logic [3:0]      acc;        // Accumulator
	logic            zf;         // Zero flag
	logic            cf;         // Carry flag
	logic [PC_W-1:0] pc;         // Program counter
	logic            busy;       // Core is not halted

	modport regs (output run, pc_load, pc_wdata, rom_page, data_page,
		input acc, zf, cf, pc, busy);
	modport core (input run, pc_load, pc_wdata, rom_page, data_page,
		output acc, zf, cf, pc, busy);
endinterface

// File: rtl/nbx_alu.sv
// Four-bit ALU: sums, differences, logic, increment and decrement
`timescale 1ns/1ps
module nbx_alu
	import nbx_pkg::*;
(
	input  wire logic [3:0]  a,      // Memory operand
	input  wire logic [3:0]  b,      // Accumulator or immediate
	input  wire logic        cin,    // Current carry flag
	input  wire nbx_alu_op_e op,     // Operation
	output logic      [3:0]  res,    // Four-bit result
	output logic             carry   // Carry out or borrow
);
	logic [4:0] wide;  // Result with carry or borrow in bit 4

	// Carry is the fifth bit of the sum; borrow is the wrapped fifth bit
	always_comb begin
		wide = 5'h00;
		case (op)
			NBX_OP_ADD: wide = {1'b0, a} + {1'b0, b};
			NBX_OP_ADC: wide = {1'b0, a} + {1'b0, b} + {4'h0, cin};
			NBX_OP_SUB: wide = {1'b0, a} - {1'b0, b};
			NBX_OP_SBC: wide = {1'b0, a} - {1'b0, b} - {4'h0, cin};
			NBX_OP_AND: wide = {1'b0, a & b};
			NBX_OP_OR:  wide = {1'b0, a | b};
			NBX_OP_XOR: wide = {1'b0, a ^ b};
			NBX_OP_INC: wide = {1'b0, a} + 5'h01;
			NBX_OP_DEC: wide = {1'b0, a} - 5'h01;
			default:    wide = 5'h00;
		endcase
		res   = wide[3:0];
		carry = wide[4];
	end
endmodule

// File: rtl/nbx_apb_regs.sv
// APB slave holding the control, status, program counter and page registers
`timescale 1ns/1ps
`include "nbx_consts.svh"
module nbx_apb_regs
	import nbx_pkg::*;
#(
	parameter int PC_W = 13
) (
	input  wire logic        clk,      // Core clock
	input  wire logic        reset,    // Synchronous, active high
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB access phase
	input  wire logic        pwrite,   // APB direction
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error on unmapped address
	nbx_ctl_if.regs          ctl       // Control towards the core
);
	typedef struct packed {
		logic            ready;
		logic            err;
		logic [31:0]     rdata;
		logic            run;
		logic            pc_load;
		logic [PC_W-1:0] pc_wdata;
		logic [1:0]      rom_page;
		logic [2:0]      data_page;
	} nbx_regs_s;

	nbx_regs_s s_q;  // Registered state
	nbx_regs_s s_d;  // Next state

	// Access phase takes two cycles so read data comes from a flop
	always_comb begin
		s_d         = s_q;
		s_d.pc_load = 1'b0;
		if (psel && penable && !s_q.ready) begin
			s_d.ready = 1'b1;
			s_d.err   = 1'b0;
			s_d.rdata = 32'h0000_0000;
			case (paddr)
				`NBX_REG_CTRL:   s_d.rdata[`NBX_CTRL_RUN] = s_q.run;
				`NBX_REG_STATUS: begin
					s_d.rdata[`NBX_STAT_ACC_LSB +: 4] = ctl.acc;
					s_d.rdata[`NBX_STAT_ZF]           = ctl.zf;
					s_d.rdata[`NBX_STAT_CF]           = ctl.cf;
					s_d.rdata[`NBX_STAT_BUSY]         = ctl.busy;
				end
				`NBX_REG_PC:     s_d.rdata[PC_W-1:0] = ctl.pc;
				`NBX_REG_PAGE: begin
					s_d.rdata[`NBX_PAGE_ROM_LSB +: 2]  = s_q.rom_page;
					s_d.rdata[`NBX_PAGE_DATA_LSB +: 3] = s_q.data_page;
				end
				default:         s_d.err = 1'b1;  // Unmapped: error, reads zero
			endcase
			// Writes answer with zero data so stale values never leak onto the bus
			if (pwrite) begin
				s_d.rdata = 32'h0000_0000;
			end
		end else if (psel && penable && s_q.ready) begin
			// Completing edge: writes land here and nowhere else
			s_d.ready = 1'b0;
			s_d.rdata = 32'h0000_0000;  // Read data stands for the answer cycle only
			if (pwrite) begin
				case (paddr)
					`NBX_REG_CTRL: s_d.run = pwdata[`NBX_CTRL_RUN];
					`NBX_REG_PC: begin
						s_d.pc_load  = 1'b1;
						s_d.pc_wdata = pwdata[PC_W-1:0];
					end
					`NBX_REG_PAGE: begin
						s_d.rom_page  = pwdata[`NBX_PAGE_ROM_LSB +: 2];
						s_d.data_page = pwdata[`NBX_PAGE_DATA_LSB +: 3];
					end
					default: s_d.run = s_q.run;  // Status is read only
				endcase
			end
		end else begin
			s_d.ready = 1'b0;
			s_d.rdata = 32'h0000_0000;  // Idle bus reads zero
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.rom_page  <= `NBX_RST_ROM_PAGE;
			s_q.data_page <= `NBX_RST_DATA_PAGE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata        = s_q.rdata;
	assign pready        = s_q.ready;
	assign pslverr       = s_q.err & s_q.ready;
	assign ctl.run       = s_q.run;
	assign ctl.pc_load   = s_q.pc_load;
	assign ctl.pc_wdata  = s_q.pc_wdata;
	assign ctl.rom_page  = s_q.rom_page;
	assign ctl.data_page = s_q.data_page;
endmodule

// File: verif/nbx_mem_model.sv
// Program ROM and data RAM seen from the far side of the execute unit
`timescale 1ns/1ps
module nbx_mem_model #(
	parameter int PC_W   = 13,  // Program address width
	parameter int RAM_AW = 7    // Data address width
) (
	input  wire logic              clk,        // Core clock
	input  wire logic [PC_W-1:0]   prog_addr,  // Program address
	output logic      [15:0]       prog_data,  // Program word
	input  wire logic [RAM_AW-1:0] ram_addr,   // Data address
	output logic      [3:0]        ram_rdata,  // Data nibble
	input  wire logic [3:0]        ram_wdata,  // Write nibble
	input  wire logic              ram_we      // Write strobe
);
	logic [15:0] rom [2**PC_W];    // Loaded by the bench
	logic [3:0]  ram [2**RAM_AW];  // Preset by the bench
	// Both reads lag the address by one cycle; a write lands on the strobe edge
	always @(posedge clk) begin
		prog_data <= rom[prog_addr];
		ram_rdata <= ram[ram_addr];
		if (ram_we)
			ram[ram_addr] <= ram_wdata;
	end
endmodule

// File: verif/nbx_exec_asserts.sv
// Port checks on the execute unit: bus answer timing and nibble write-back
`timescale 1ns/1ps
module nbx_exec_asserts #(
	parameter int PC_W   = 13,  // Program address width
	parameter int RAM_AW = 7    // Data address width
) (
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [PC_W-1:0]   prog_addr,
	input wire logic [RAM_AW-1:0] ram_addr,
	input wire logic              ram_we
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_ready_wait;
		psel && $rose(penable) |-> !pready ##1 pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready not in second access cycle");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
	property p_err_map;
		pready |-> (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}));
	endproperty
	a_err_map: assert property (p_err_map) else $error("error response wrong for address");
	property p_err_only;
		pslverr |-> pready;
	endproperty
	a_err_only: assert property (p_err_only) else $error("error outside answer cycle");
	property p_rdata_idle;
		!(pready && !pwrite && !pslverr) |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
	property p_we_once;
		ram_we |=> !ram_we [*3];
	endproperty
	a_we_once: assert property (p_we_once) else $error("second write within one step");
	property p_we_addr;
		ram_we |-> $stable(ram_addr) && ram_addr == $past(ram_addr, 2);
	endproperty
	a_we_addr: assert property (p_we_addr) else $error("write not to operand address");
	property p_pc_hold;
		$changed(prog_addr) |=> $stable(prog_addr) [*3];
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("program address moved mid-step");
endmodule

bind nbx_exec nbx_exec_asserts #(.PC_W(PC_W), .RAM_AW(RAM_AW)) u_chk (
	.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.prog_addr(prog_addr), .ram_addr(ram_addr), .ram_we(ram_we));

// File: verif/testbench.sv
// Bench: steps single instructions through APB control over preloaded memories
`timescale 1ns/1ps
module testbench;
	logic        clk;        // 100 MHz
	logic        reset;      // Synchronous, active high
	logic        psel;       // APB request lines
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;     // APB answer lines
	logic        pready;
	logic        pslverr;
	logic [12:0] prog_addr;  // Memory side
	logic [15:0] prog_data;
	logic [6:0]  ram_addr;
	logic [3:0]  ram_rdata;
	logic [3:0]  ram_wdata;
	logic        ram_we;
	logic [31:0] rd;         // Last read data
	logic        er;         // Last error response
	logic [3:0]  m_acc;      // Expected accumulator and flags
	logic        m_zf;
	logic        m_cf;
	logic [12:0] m_pc;       // Expected program counter after a step
	logic [3:0]  mr [128];   // Expected RAM
	logic [1:0]  rp;         // ROM page in use
	logic [2:0]  dp;         // Data page in use
	logic [7:0]  hi;         // Opcode sweep
	logic [7:0]  lo;
	logic [12:0] step_pc = 13'h1100;  // Above page 1 so kept upper PC bits show
	logic [15:0] pre [4] = '{16'h4a90, 16'h4a90, 16'h2a01, 16'h1805};  // Flag setups
	logic [15:0] misc [10] = '{16'h4a30, 16'h4ab0, 16'h4a0f, 16'h4820, 16'h4820,
		16'h48a0, 16'ha805, 16'ha885, 16'ha905, 16'ha985};
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;

	nbx_exec #(.PC_W(13), .RAM_AW(7)) DUT (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
		.prog_data(prog_data), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
		.ram_wdata(ram_wdata), .ram_we(ram_we));
	nbx_mem_model #(.PC_W(13), .RAM_AW(7)) mem (.clk(clk), .prog_addr(prog_addr),
		.prog_data(prog_data), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
		.ram_wdata(ram_wdata), .ram_we(ram_we));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: a run this long means a lost handshake
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			results();
		end
	end

	task automatic results();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the answer is taken at the rising edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Expected effect of one instruction at step_pc
	task automatic model(input logic [15:0] w);
		logic [7:0] h;
		logic [6:0] ad;
		logic [3:0] a;
		logic [3:0] b;
		logic [4:0] s;
		logic       alu;
		h = w[15:8];
		ad = h[2] ? {dp, w[3:0]} : w[6:0];
		a = mr[ad];
		b = h[2] ? w[7:4] : m_acc;
		m_pc = step_pc + 13'h1;
		alu = 1'b0;
		if (h[7:6] == 2'b00 && h[3]) begin
			alu = 1'b1;
			case ({h[5:4], h[1]})
				3'b000: s = a + b + m_cf;
				3'b001: s = a - b - m_cf;
				3'b010: s = a + b;
				3'b011: s = a - b;
				3'b100: s = {m_cf, a + b};
				3'b101: s = {m_cf, a & b};
				3'b110: s = {m_cf, a ^ b};
				default: s = {m_cf, a | b};
			endcase
		end else if (h == 8'h4a || h == 8'h48) begin
			alu = 1'b1;
			s = (w[7] || !h[1]) ? a - 5'h1 : a + 5'h1;
			if (!h[1] && ((s[3:0] == 4'h0) != w[7]))
				m_pc = step_pc + 13'h2;
		end else if (h[7] && !h[3]) begin
			if (h[6] ? (h[4] ? h[5] == m_cf : h[5] == (m_acc == 4'h0)) : m_acc[h[5:4]])
				m_pc = {step_pc[12:11], w[10:0]};
		end else if (h[7:1] == 7'h54) begin
			if (a[{h[0], w[7]}])
				m_pc = step_pc + 13'h2;
		end else if (h[7:3] == 5'h0e)
			m_pc = {rp, w[10:0]};
		// Zero from the nibble, carry or borrow from bit 4
		if (alu) begin
			m_acc = s[3:0];
			m_zf = (s[3:0] == 4'h0);
			m_cf = s[4];
			if (h[0] || h[6])
				mr[ad] = s[3:0];
		end
	endtask

	// Place one instruction, run it, stop, then compare state, PC and RAM
	task automatic run_op(input logic [15:0] w);
		int n;
		mem.rom[step_pc] = w;
		model(w);
		apb(1'b1, 8'h08, 32'(step_pc));
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h08, 32'h0);
		repeat (8) @(posedge clk);
		apb(1'b1, 8'h00, 32'h0);
		n = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end while (rd[8] !== 1'b0 && n < 8);
		check(rd[15:0], 16'({m_cf, m_zf, m_acc}));
		apb(1'b0, 8'h08, 32'h0);
		check(rd[15:0], 16'(m_pc));
		for (int i = 0; i < 128; i++)
			check(16'(mem.ram[i]), 16'(mr[i]));
		mem.rom[step_pc] = 16'h7000 | 16'(step_pc[10:0]);
	endtask

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		m_acc = 4'h0;
		m_zf = 1'b0;
		m_cf = 1'b0;
		rp = 2'h2;
		dp = 3'h5;
		// Every word jumps to its own offset in the selected ROM page, so the core parks where a step leaves it
		for (int i = 0; i < 8192; i++)
			mem.rom[i] = 16'h7000 | 16'(i & 32'h7ff);
		for (int i = 0; i < 128; i++) begin
			mr[i] = 4'(i ^ (i >> 4));
			mem.ram[i] = mr[i];
		end
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			check(rd[15:0], 16'h0000);
		end
		apb(1'b0, 8'h10, 32'h0);
		check(16'({er, rd[14:0]}), 16'h8000);
		apb(1'b1, 8'h04, 32'h3f);
		apb(1'b0, 8'h04, 32'h0);
		check(rd[15:0], 16'h0000);
		apb(1'b1, 8'h0c, 32'h52);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd[15:0], 16'h0052);
		// Every arithmetic and logic code, both operand forms
		for (int k = 0; k < 32; k++) begin
			lo = 8'(k * 37 + 11);
			hi = {2'b00, 2'(k >> 3), 1'b1, 3'(k)};
			if (!hi[2])
				lo[7] = 1'b0;
			run_op({hi, lo});
		end
		foreach (pre[i]) begin
			run_op(pre[i]);
			for (int j = 8; j < 16; j++)
				run_op({4'(j), 12'h555});
		end
		foreach (misc[i])
			run_op(misc[i]);
		rp = 2'h3;
		apb(1'b1, 8'h0c, 32'h53);
		run_op(16'h7123);
		results();
	end
endmodule
